// [rtl/dph_defines.svh]
// Constants for the DMA peripheral handshake block
// Behaviour
// R01: The peripheral drives the request line active when it wants one operand moved.
// R02: In cycle-steal mode each asserting edge of the request line yields exactly one transfer request.
// R03: In burst mode requests keep coming for as long as the request line stays asserted.
// R04: The acknowledge output is asserted while an operand is moved in answer to a peripheral request.
// R05: The end-of-block line is open-drain and either side may pull it low in a bus cycle to mark the last item.
// R06: The engine drives end-of-block low during the bus cycle in which its byte count reaches zero.
// R07: When not driving end-of-block the engine samples it and a peripheral assertion ends the operation.
// R08: Each handshake pin is individually selectable as its DMA function or as a port A line.
// R09: Memory-to-memory transfers need no handshake pin, freeing all three for port use.
// R10: The peripheral holds the request low at least two clock cycles to be recognised.
// R11: Within two clocks of the request going low the bus request output is asserted; the code needs three: two synchroniser flops, then the bus request register.
// R12: Outside transfer cycles acknowledge stays negated and end-of-block is released.
`ifndef DPH_DEFINES_SVH
`define DPH_DEFINES_SVH
`define DPH_CLK_HZ       20000000
`define DPH_REQ_LOW_CLKS 2
`define DPH_REQ_BR_CLKS  2
`define DPH_CNT_W        16
`define DPH_DATA_W       16
`define DPH_FIFO_DEPTH   8
`define DPH_PIN_REQ      0
`define DPH_PIN_ACK      1
`define DPH_PIN_DONE     2
`endif

// [rtl/dph_pkg.sv]
// Types for the DMA peripheral handshake block
package dph_pkg;
  typedef enum logic [3:0] {
    DPH_IDLE  = 4'b0001,
    DPH_BREQ  = 4'b0010,
    DPH_XFER  = 4'b0100,
    DPH_END   = 4'b1000
  } dph_state_e;
  typedef enum logic [1:0] {
    DPH_MODE_STEAL = 2'b00,
    DPH_MODE_BURST = 2'b01,
    DPH_MODE_M2M   = 2'b10
  } dph_mode_e;
endpackage

// [rtl/dph_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dph_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             wr, rd;

  // Read data from memory is combinational off a registered pointer
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_comb begin
    wp_next  = wr ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next  = rd ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg;
    if (wr && !rd) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (rd && !wr) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (wr) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [rtl/dph_handshake.sv]
// DMA peripheral handshake: request, acknowledge, end-of-block, port A sharing
`timescale 1ns/1ns
`default_nettype none
`include "dph_defines.svh"
module dph_handshake (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire dph_pkg::dph_mode_e       mode,
  input  wire logic                     start,
  input  wire logic [`DPH_CNT_W-1:0]    byte_count,
  input  wire logic [2:0]               pin_is_dma,
  input  wire logic [2:0]               porta_out,
  input  wire logic [2:0]               porta_oe,
  output logic      [2:0]               porta_in,
  input  wire logic                     porta_line_13_i,
  output logic                          porta_line_13_o,
  output logic                          porta_line_13_oe,
  input  wire logic                     porta_line_14_i,
  output logic                          porta_line_14_o,
  output logic                          porta_line_14_oe,
  input  wire logic                     porta_line_15_i,
  output logic                          porta_line_15_o,
  output logic                          porta_line_15_oe,
  output logic                          bus_req,
  input  wire logic                     bus_grant,
  input  wire logic                     cycle_end,
  input  wire logic [`DPH_DATA_W-1:0]   src_data,
  input  wire logic                     src_valid,
  output logic                          src_ready,
  output logic      [`DPH_DATA_W-1:0]   dst_data,
  output logic                          dst_valid,
  input  wire logic                     dst_ready,
  output logic                          busy,
  output logic                          done_by_count,
  output logic                          done_by_peer
);
  import dph_pkg::*;

  // Pins arrive from outside: two flops before anything looks at them
  logic [2:0] pin_s1_reg, pin_s2_reg;
  logic [2:0] pin_s1_next, pin_s2_next;
  logic       req_prev_reg, req_prev_next;

  dph_state_e            st_reg, st_next;
  logic [`DPH_CNT_W-1:0] cnt_reg, cnt_next;
  logic                  pend_reg, pend_next;
  logic                  by_cnt_reg, by_cnt_next;
  logic                  by_peer_reg, by_peer_next;
  logic                  ack_reg, ack_next;
  logic                  done_drv_reg, done_drv_next;
  logic                  br_reg, br_next;

  logic                  req_low, req_fall, req_seen;
  logic                  peer_done, last_item, xfer_fire;
  logic                  fifo_in_ready;

  // Active-low pin asserted when sampled low
  function automatic logic pin_low(input logic [2:0] v, input int idx);
    return !v[idx];
  endfunction

  always_comb begin
    pin_s1_next   = {porta_line_15_i, porta_line_14_i, porta_line_13_i};
    pin_s2_next   = pin_s1_reg;
    req_prev_next = pin_s2_reg[`DPH_PIN_REQ];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_reg   <= 3'h7;
      pin_s2_reg   <= 3'h7;
      req_prev_reg <= 1'b1;
    end else begin
      pin_s1_reg   <= pin_s1_next;
      pin_s2_reg   <= pin_s2_next;
      req_prev_reg <= req_prev_next;
    end
  end

  assign porta_in = pin_s2_reg;

  // Request is ignored when its pin belongs to port A
  assign req_low  = pin_is_dma[`DPH_PIN_REQ] && pin_low(pin_s2_reg, `DPH_PIN_REQ); // [R01]
  assign req_fall = req_low && req_prev_reg; // [R02]
  // Steal counts edges, burst honours level, m2m ignores the pin
  always_comb begin
    unique case (mode)
      DPH_MODE_STEAL: req_seen = req_fall || pend_reg; // [R02]
      DPH_MODE_BURST: req_seen = req_low;               // [R03]
      DPH_MODE_M2M:   req_seen = 1'b1;                  // [R09]
      default:        req_seen = 1'b0;
    endcase
  end

  // Peer end-of-block only counts when we are not pulling the line ourselves
  assign peer_done = pin_is_dma[`DPH_PIN_DONE] && !done_drv_reg
                     && pin_low(pin_s2_reg, `DPH_PIN_DONE)
                     && (st_reg == DPH_XFER); // [R07]
  assign last_item = (cnt_reg == `DPH_CNT_W'(1));
  assign xfer_fire = (st_reg == DPH_XFER) && cycle_end && fifo_in_ready;

  always_comb begin
    st_next       = st_reg;
    cnt_next      = cnt_reg;
    pend_next     = pend_reg;
    by_cnt_next   = by_cnt_reg;
    by_peer_next  = by_peer_reg;
    ack_next      = 1'b0;   // [R12]
    done_drv_next = 1'b0;   // [R12]
    br_next       = 1'b0;
    // Edge that arrives while busy is kept, not lost
    if (mode == DPH_MODE_STEAL && req_fall && st_reg != DPH_IDLE) begin
      pend_next = 1'b1; // [R02]
    end
    unique case (st_reg)
      DPH_IDLE: begin
        if (start && byte_count != '0) begin
          cnt_next     = byte_count;
          by_cnt_next  = 1'b0;
          by_peer_next = 1'b0;
          pend_next    = 1'b0;
          st_next      = DPH_BREQ;
        end
      end
      DPH_BREQ: begin
        if (br_reg) begin
          // Request stands until granted, whatever the pin does meanwhile
          br_next = 1'b1; // [R11]
          if (bus_grant) begin
            br_next       = 1'b0;
            ack_next      = (mode != DPH_MODE_M2M) && pin_is_dma[`DPH_PIN_ACK]; // [R04] [R08]
            done_drv_next = last_item && pin_is_dma[`DPH_PIN_DONE]; // [R06]
            st_next       = DPH_XFER;
          end
        end else if (req_seen) begin
          br_next   = 1'b1; // [R11]
          // One edge, one item: a fresh edge is kept only if a stored one was used
          pend_next = pend_reg && req_fall; // [R02]
        end
      end
      DPH_XFER: begin
        ack_next      = ack_reg;       // [R04]
        done_drv_next = done_drv_reg;  // [R06]
        if (peer_done) begin
          by_peer_next = 1'b1; // [R07]
          st_next      = DPH_END;
          ack_next     = 1'b0;
        end else if (xfer_fire) begin
          cnt_next      = `DPH_CNT_W'(cnt_reg - 1'b1);
          ack_next      = 1'b0;
          done_drv_next = 1'b0;
          if (last_item) begin
            by_cnt_next = 1'b1; // [R06]
            st_next     = DPH_END;
          end else begin
            st_next = DPH_BREQ;
          end
        end
      end
      DPH_END: begin
        st_next = DPH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg       <= DPH_IDLE;
      cnt_reg      <= '0;
      pend_reg     <= 1'b0;
      by_cnt_reg   <= 1'b0;
      by_peer_reg  <= 1'b0;
      ack_reg      <= 1'b0;
      done_drv_reg <= 1'b0;
      br_reg       <= 1'b0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      pend_reg     <= pend_next;
      by_cnt_reg   <= by_cnt_next;
      by_peer_reg  <= by_peer_next;
      ack_reg      <= ack_next;
      done_drv_reg <= done_drv_next;
      br_reg       <= br_next;
    end
  end

  // Operand path; a full FIFO stalls the bus cycle
  dph_fifo #(
    .WIDTH (`DPH_DATA_W),
    .DEPTH (`DPH_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (src_data),
    .in_valid  (src_valid && (st_reg == DPH_XFER)),
    .in_ready  (fifo_in_ready),
    .out_data  (dst_data),
    .out_valid (dst_valid),
    .out_ready (dst_ready)
  );
  assign src_ready = fifo_in_ready && (st_reg == DPH_XFER);

  assign bus_req       = br_reg;
  assign busy          = (st_reg != DPH_IDLE);
  assign done_by_count = by_cnt_reg;
  assign done_by_peer  = by_peer_reg;

  // Pin muxing: each pin DMA or port A on its own
  assign porta_line_13_o  = porta_out[0];
  assign porta_line_13_oe = !pin_is_dma[`DPH_PIN_REQ] && porta_oe[0]; // [R08]
  assign porta_line_14_o  = pin_is_dma[`DPH_PIN_ACK] ? !ack_reg : porta_out[1]; // [R04]
  assign porta_line_14_oe = pin_is_dma[`DPH_PIN_ACK] ? 1'b1 : porta_oe[1]; // [R08]
  // Open drain when the pin is end-of-block: only ever drive low, release otherwise; as port A it passes porta_out
  assign porta_line_15_o  = pin_is_dma[`DPH_PIN_DONE] ? 1'b0 : porta_out[2]; // [R05]
  assign porta_line_15_oe = pin_is_dma[`DPH_PIN_DONE] ? done_drv_reg : porta_oe[2]; // [R05] [R12]
endmodule
`default_nettype wire

// [tb/dph_handshake_props.sv]
// Concurrent checks on the DMA handshake ports
`timescale 1ns/1ns
`default_nettype none
module dph_handshake_props (
  input wire logic               clk,
  input wire logic               srst,
  input wire dph_pkg::dph_mode_e mode,
  input wire logic [2:0]         pin_is_dma,
  input wire logic [2:0]         porta_out,
  input wire logic [2:0]         porta_oe,
  input wire logic               porta_line_13_i,
  input wire logic               porta_line_14_o,
  input wire logic               porta_line_14_oe,
  input wire logic               porta_line_15_i,
  input wire logic               porta_line_15_o,
  input wire logic               porta_line_15_oe,
  input wire logic               bus_req,
  input wire logic               bus_grant,
  input wire logic               busy,
  input wire logic               done_by_peer
);
  import dph_pkg::*;
  logic [2:0] dma_q;
  logic [2:0] dma_st;
  // Pin choice held two samples, so ack and end-of-block state registered under the old choice is never caught mid-switch
  always_ff @(posedge clk) dma_q <= pin_is_dma;
  assign dma_st = dma_q & pin_is_dma;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_idle: assert property (dma_st[1] && !busy |-> porta_line_14_o && porta_line_14_oe)
    else $error("ack asserted while idle");
  a_done_idle: assert property (dma_st[2] && !busy |-> !porta_line_15_oe)
    else $error("end-of-block driven while idle");
  a_done_low: assert property (dma_st[2] && porta_line_15_oe |-> !porta_line_15_o)
    else $error("end-of-block driven high");
  a_ack_cause: assert property (dma_st[1] && !porta_line_14_o |-> busy && mode != DPH_MODE_M2M)
    else $error("ack without a peripheral transfer");
  a_req_answer: assert property (dma_st[0] && dma_st[1] && mode != DPH_MODE_M2M && busy && !bus_req
    && porta_line_14_o && $fell(porta_line_13_i) ##1 !porta_line_13_i |-> ##[1:4] (bus_req || !busy))
    else $error("request not answered by bus request");
  a_br_hold: assert property (bus_req && !bus_grant |=> bus_req)
    else $error("bus request dropped before grant");
  a_peer_end: assert property ((dma_st[2] && dma_st[1] && busy && !porta_line_14_o && !porta_line_15_oe
    && !porta_line_15_i) [*2] |-> ##[0:4] done_by_peer)
    else $error("peer end-of-block ignored");
  a_port_pass: assert property ((!pin_is_dma[1] && $stable(porta_out) && $stable(porta_oe)) [*3]
    |-> porta_line_14_oe == porta_oe[1] && (!porta_oe[1] || porta_line_14_o == porta_out[1]))
    else $error("port A drive not passed to pin");
endmodule
bind dph_handshake dph_handshake_props dph_handshake_props_inst (.*);
`default_nettype wire

// [tb/dph_peer_model.sv]
// Peripheral on the far side of the DMA handshake
`timescale 1ns/1ns
`default_nettype none
module dph_peer_model (
  input  wire logic clk,
  input  wire logic steal_en,
  input  wire logic hold_req,
  input  wire logic kill,
  input  wire logic ack_level,
  output logic      req_level,
  output logic      done_pull
);
  logic [2:0] ph_reg;
  always_ff @(posedge clk) begin
    ph_reg <= steal_en ? ph_reg + 3'h1 : 3'h0;
    done_pull <= kill && !ack_level;
  end
  // Low three clocks of eight, above the minimum width
  assign req_level = !(hold_req || (steal_en && ph_reg < 3'h3));
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the DMA peripheral handshake
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dph_pkg::*;
  logic        clk, srst, start, bus_req, bus_grant, cycle_end, src_valid, src_ready, dst_valid, dst_ready;
  logic        busy, done_by_count, done_by_peer, req_level, done_pull, steal_en, hold_req, kill, drain;
  logic        porta_line_13_i, porta_line_13_o, porta_line_13_oe, porta_line_14_i, porta_line_14_o;
  logic        porta_line_14_oe, porta_line_15_i, porta_line_15_o, porta_line_15_oe;
  dph_mode_e   mode;
  logic [15:0] byte_count, src_data, dst_data;
  logic [2:0]  pin_is_dma, porta_out, porta_oe, porta_in, pin_rnd;
  logic [31:0] rnd;
  int          miscompares, total_checks, n_items, blk_len;
  logic [15:0] q[$];
  dph_handshake dph_handshake_inst (.*);
  dph_peer_model dph_peer_model_inst (.clk(clk), .steal_en(steal_en), .hold_req(hold_req), .kill(kill),
    .ack_level(porta_line_14_i), .req_level(req_level), .done_pull(done_pull));
  // Released port lines take random levels: pin_rnd is reloaded every cycle; released DMA pins see the peer or a pull-up
  assign porta_line_13_i = porta_line_13_oe ? porta_line_13_o : pin_is_dma[0] ? req_level : pin_rnd[0];
  assign porta_line_14_i = porta_line_14_oe ? porta_line_14_o : pin_rnd[1];
  assign porta_line_15_i = !done_pull && (porta_line_15_oe ? porta_line_15_o : pin_is_dma[2] | pin_rnd[2]);
  assign src_valid = cycle_end;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    rnd <= lfsr(rnd);
    bus_grant <= bus_req && rnd[7];
    cycle_end <= src_ready && !cycle_end && rnd[3] && !kill;
    dst_ready <= drain && rnd[5];
    src_data <= rnd[31:16];
    pin_rnd <= rnd[10:8];
  end
  always @(posedge clk) begin
    if (!srst && cycle_end && src_ready) begin
      if (pin_is_dma[2]) check(porta_line_15_oe, n_items + 1 == blk_len);
      check(q.size() < 8, 1'h1);
      q.push_back(src_data);
      n_items++;
    end
    if (!srst && dst_valid && dst_ready) check(dst_data, q.pop_front());
  end
  task automatic run_block(input dph_mode_e m, input int len, input logic [2:0] pins, input logic kl);
    int i;
    @(negedge clk);
    mode = m;
    pin_is_dma = pins;
    byte_count = len[15:0];
    blk_len = len;
    n_items = 0;
    porta_out = rnd[2:0];
    porta_oe = rnd[6:4];
    steal_en = (m == DPH_MODE_STEAL);
    hold_req = (m == DPH_MODE_BURST);
    drain = (len <= 8);
    start = 1;
    @(negedge clk);
    start = 0;
    for (i = 0; i < 3000 && busy; i++) begin
      @(negedge clk);
      if (kl && n_items == 2) kill = 1;
      if (!drain && n_items == 8) begin
        repeat (10) @(negedge clk);
        check(porta_line_14_o, 0);
        drain = 1;
      end
    end
    steal_en = 0;
    hold_req = 0;
    kill = 0;
    drain = 1;
    repeat (30) @(negedge clk);
    check(busy, 0);
    check(done_by_peer, kl);
    check(done_by_count, !kl);
    check(n_items, kl ? 2 : blk_len);
    check(q.size(), 0);
    $display("test done mode %0d length %0d", m, len);
  endtask
  initial begin
    {srst, start, bus_grant, cycle_end, dst_ready, steal_en, hold_req, kill, drain} = 9'h101;
    mode = DPH_MODE_STEAL;
    {byte_count, src_data, pin_is_dma, porta_out, porta_oe, pin_rnd} = 44'hE00;
    rnd = 32'h79D2F4FC;
    {miscompares, total_checks, n_items, blk_len} = 0;
    repeat (6) @(negedge clk);
    srst = 0;
    check({bus_req, porta_line_14_o, porta_line_15_oe}, 3'h2);
    run_block(DPH_MODE_STEAL, 5, 3'h7, 0);
    run_block(DPH_MODE_BURST, 12, 3'h7, 0);
    run_block(DPH_MODE_M2M, 3 + rnd[1:0], 3'h0, 0);
    run_block(DPH_MODE_STEAL, 4, 3'h3, 0);
    run_block(DPH_MODE_STEAL, 9, 3'h7, 1);
    run_block(DPH_MODE_BURST, 1, 3'h7, 0);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
